// >>> bench/ecc_control_asserts.sv
`timescale 1ns/10ps
module ecc_control_asserts
  import ecc_pkg::*;
#(
  parameter int STRAP_DELAY_CYCLES = STRAP_DELAY_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sample_valid,
  input wire logic signed [15:0] tx_sample_in,
  input wire logic signed [15:0] serial_out_pin,
  input wire logic far_active,
  input wire logic near_active,
  input wire ecc_codec_ctl_t codec_ctl,
  input wire ecc_cancel_ctl_t cancel_ctl,
  input wire logic [3:0] tx_volume_field,
  input wire logic [5:0] rx_volume,
  input wire logic rx_agc_enable,
  input wire logic rx_pass,
  input wire logic rx_full_on,
  input wire logic tx_suppress_enable,
  input wire logic duplex_status_pin
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_codec_rst;
    $fell(rst) |-> !codec_ctl.codec_power_down &&
      !codec_ctl.speaker_power_down && tx_volume_field == 4'h0;
  endproperty
  a_codec_rst: assert property (p_codec_rst)
    else $error("codec word not cleared by reset");
  property p_half_rst;
    $fell(rst) |-> !duplex_status_pin && rx_volume == 6'h04;
  endproperty
  a_half_rst: assert property (p_half_rst)
    else $error("not half duplex after reset");
  property p_tx_pass;
    sample_valid && duplex_status_pin && !rx_full_on &&
      tx_volume_field == 4'h0 |=> serial_out_pin == $past(tx_sample_in);
  endproperty
  a_tx_pass: assert property (p_tx_pass)
    else $error("unattenuated sample not passed");
  property p_half_block;
    sample_valid && !duplex_status_pin && rx_pass && !rx_full_on
      |=> serial_out_pin == 16'sh0000;
  endproperty
  a_half_block: assert property (p_half_block)
    else $error("transmit passed while receive owns the line");
  property p_mute;
    rx_full_on && sample_valid |-> rx_pass ##1 serial_out_pin == 16'sh0000;
  endproperty
  a_mute: assert property (p_mute)
    else $error("muted path sent nonzero sample");
  property p_agc_off;
    rx_volume == VOLUME_AGC_OFF |-> !rx_agc_enable;
  endproperty
  a_agc_off: assert property (p_agc_off)
    else $error("receive gain control on at volume ten");
  property p_supp;
    tx_suppress_enable |-> duplex_status_pin;
  endproperty
  a_supp: assert property (p_supp)
    else $error("supplementary suppression outside full duplex");
  property p_keep_full;
    duplex_status_pin && !cancel_ctl.aec_coef_clear &&
      !cancel_ctl.nec_coef_clear |=> duplex_status_pin;
  endproperty
  a_keep_full: assert property (p_keep_full)
    else $error("left full duplex without a coefficient clear");
  property p_adapt;
    cancel_ctl.adapt_strobe == (sample_valid && (far_active || near_active));
  endproperty
  a_adapt: assert property (p_adapt)
    else $error("adaptation not tied to live speech");
  property p_span;
    cancel_ctl.aec_full_span != cancel_ctl.net_canceller_enable;
  endproperty
  a_span: assert property (p_span)
    else $error("echo span not given to acoustic canceller");
endmodule // ecc_control_asserts

// >>> bench/ecc_host_model.sv
`timescale 1ns/10ps
module ecc_host_model
  import ecc_pkg::*;
#(
  parameter int PERIOD = 25
) (
  input wire logic clk,
  input wire logic rst,
  output logic sample_valid,
  output logic signed [15:0] tx_sample_in
);
  // The sample steps every period so a stale output never passes as fresh.
  int cnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      sample_valid <= 1'b0;
      tx_sample_in <= 16'sh1000;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      sample_valid <= (cnt == PERIOD - 1);
      if (cnt == 0) begin
        tx_sample_in <= tx_sample_in + 16'sh0104;
      end
    end
  end
endmodule // ecc_host_model

// >>> bench/tb_ecc_control.sv
`timescale 1ns/10ps
module tb_ecc_control;
  import ecc_pkg::*;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic link_wr_valid = 1'b0;
  logic link_wr_ready;
  ecc_word_wr_t link_wr = '0;
  logic [1:0] link_rd_sel = 2'h0;
  logic [11:0] link_rd_data;
  logic sample_valid;
  logic signed [15:0] tx_sample_in, serial_out_pin, s;
  logic far_active = 1'b0;
  logic near_active = 1'b0;
  logic [7:0] erle_level = 8'h00;
  logic mute_gain_pin = 1'b0;
  logic [2:0] control_code_pins = 3'h4;
  ecc_codec_ctl_t codec_ctl;
  ecc_cancel_ctl_t cancel_ctl;
  logic [3:0] tx_volume_field;
  logic [5:0] rx_volume;
  logic rx_agc_enable, rx_pass, rx_full_on, tx_suppress_enable;
  logic duplex_status_pin;
  int bad_count = 0;
  int n_tests = 0;
  ecc_control #(.STRAP_DELAY_CYCLES(200)) DUT (.clk, .rst, .link_clk,
    .link_wr_valid, .link_wr_ready, .link_wr, .link_rd_sel, .link_rd_data,
    .sample_valid, .tx_sample_in, .serial_out_pin, .far_active,
    .near_active, .erle_level, .mute_gain_pin, .control_code_pins,
    .codec_ctl, .cancel_ctl, .tx_volume_field, .rx_volume, .rx_agc_enable,
    .rx_pass, .rx_full_on, .tx_suppress_enable, .duplex_status_pin);
  ecc_host_model HM (.clk, .rst, .sample_valid, .tx_sample_in);
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    #3;
    forever #80 link_clk = ~link_clk;
  end
  task wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Request is held for one link_clk edge, taken only if ready then; ready is then awaited.
  task automatic wr(input logic [1:0] sel, input logic [11:0] d);
    int i;
    @(posedge link_clk);
    link_wr_valid <= 1'b1;
    link_wr <= '{sel: sel, data: d};
    @(posedge link_clk);
    link_wr_valid <= 1'b0;
    #1;
    for (i = 0; i < 40 && link_wr_ready !== 1'b1; i++) begin
      @(posedge link_clk);
      #1;
    end
    if (i == 40) begin
      bad_count++;
      wrap_up();
    end
    cyc(2);
  endtask
  task automatic rd(input logic [1:0] sel, input logic [11:0] e);
    @(posedge link_clk);
    link_rd_sel <= sel;
    repeat (2) @(posedge link_clk);
    #1;
    chk(16'(link_rd_data), 16'(e));
  endtask
  task automatic smp(output logic signed [15:0] v);
    int i;
    for (i = 0; i < 60 && sample_valid !== 1'b1; i++) cyc(1);
    if (i == 60) begin
      bad_count++;
      wrap_up();
    end
    v = tx_sample_in;
    cyc(1);
  endtask
  // A code counts only after three samples of stable input.
  task automatic code(input logic [2:0] c);
    @(posedge clk);
    control_code_pins <= c;
    repeat (5) smp(s);
    @(posedge clk);
    control_code_pins <= 3'h4;
    repeat (5) smp(s);
  endtask
  initial begin
    int k;
    cyc(10);
    rst <= 1'b0;
    cyc(6);
    mute_gain_pin <= 1'b1;
    cyc(12);
    chk(16'(rx_full_on), 16'h0);
    mute_gain_pin <= 1'b0;
    chk(16'(codec_ctl), 16'h0);
    chk(16'(duplex_status_pin), 16'h0);
    chk(16'(rx_agc_enable), 16'h1);
    chk(16'(cancel_ctl.decay_rate), 16'h2);
    chk(16'(codec_ctl.mic_gain_bypass), 16'h0);
    rd(WORD_CODEC_POWER_GAIN, 12'h000);
    $display("reset test done");
    for (k = 0; k < 3; k++) begin
      wr(WORD_CODEC_POWER_GAIN, 12'h800 >> k);
      chk(16'(codec_ctl), 16'h4 >> k);
    end
    wr(WORD_CODEC_POWER_GAIN, 12'h00f);
    chk(16'(tx_volume_field), 16'hf);
    rd(WORD_CODEC_POWER_GAIN, 12'h00f);
    wr(WORD_CANCELLER_CONFIG, 12'h10e);
    chk(16'(cancel_ctl.aec_full_span), 16'h1);
    chk(16'(cancel_ctl.decay_rate), 16'h3);
    wr(WORD_CANCELLER_CONFIG, CANCELLER_CONFIG_RESET);
    chk(16'(cancel_ctl.net_canceller_enable), 16'h1);
    $display("word test done");
    wr(WORD_CODEC_POWER_GAIN, 12'h000);
    near_active <= 1'b1;
    cyc(4);
    smp(s);
    chk(serial_out_pin, s);
    far_active <= 1'b1;
    cyc(4);
    chk(16'(rx_pass), 16'h0);
    near_active <= 1'b0;
    cyc(4);
    smp(s);
    chk(serial_out_pin, 16'h0);
    chk(16'(rx_pass), 16'h1);
    far_active <= 1'b0;
    erle_level <= ERLE_THRESHOLD;
    cyc(4);
    chk(16'(duplex_status_pin), 16'h0);
    erle_level <= 8'h31;
    cyc(4);
    chk(16'(duplex_status_pin), 16'h1);
    chk(16'(tx_suppress_enable), 16'h1);
    smp(s);
    chk(serial_out_pin, s);
    wr(WORD_CODEC_POWER_GAIN, 12'h002);
    smp(s);
    chk(serial_out_pin, s >>> 1);
    erle_level <= 8'h00;
    cyc(4);
    chk(16'(duplex_status_pin), 16'h1);
    $display("duplex test done");
    wr(WORD_TEST_CONTROL, 12'h400);
    chk(16'(rx_agc_enable), 16'h0);
    wr(WORD_TEST_CONTROL, 12'h002);
    chk(16'(tx_suppress_enable), 16'h0);
    wr(WORD_TEST_CONTROL, 12'h000);
    code(CODE_VOLUME_DOWN);
    chk(16'(rx_volume), 16'h5);
    for (k = 0; k < 5; k++) code(CODE_VOLUME_DOWN);
    chk(16'(rx_volume), 16'ha);
    chk(16'(rx_agc_enable), 16'h0);
    code(CODE_VOLUME_UP);
    chk(16'(rx_volume), 16'h9);
    chk(16'(rx_agc_enable), 16'h1);
    code(CODE_COEF_CLEAR);
    chk(16'(duplex_status_pin), 16'h0);
    code(CODE_HD_DISABLE_A);
    chk(16'(duplex_status_pin), 16'h1);
    code(CODE_HD_ENABLE);
    chk(16'(duplex_status_pin), 16'h1);
    code(CODE_COEF_CLEAR);
    chk(16'(duplex_status_pin), 16'h0);
    code(CODE_HD_DISABLE_B);
    chk(16'(duplex_status_pin), 16'h1);
    $display("code test done");
    mute_gain_pin <= 1'b1;
    cyc(8);
    chk(16'(rx_full_on), 16'h1);
    smp(s);
    chk(serial_out_pin, 16'h0);
    mute_gain_pin <= 1'b0;
    cyc(8);
    chk(16'(rx_full_on), 16'h0);
    smp(s);
    chk(serial_out_pin, s >>> 1);
    $display("mute test done");
    mute_gain_pin <= 1'b1;
    cyc(4);
    rst <= 1'b1;
    cyc(32);
    rst <= 1'b0;
    cyc(10);
    chk(16'(codec_ctl), 16'h1);
    chk(16'(duplex_status_pin), 16'h0);
    chk(16'(rx_volume), 16'h4);
    cyc(210);
    chk(16'(rx_full_on), 16'h0);
    mute_gain_pin <= 1'b0;
    cyc(8);
    chk(16'(rx_full_on), 16'h1);
    smp(s);
    chk(serial_out_pin, 16'h0);
    $display("strap test done");
    wrap_up();
  end
endmodule // tb_ecc_control
bind ecc_control ecc_control_asserts #(
  .STRAP_DELAY_CYCLES(STRAP_DELAY_CYCLES)
) u_chk (.clk, .rst, .sample_valid, .tx_sample_in, .serial_out_pin,
  .far_active, .near_active, .codec_ctl, .cancel_ctl, .tx_volume_field,
  .rx_volume, .rx_agc_enable, .rx_pass, .rx_full_on, .tx_suppress_enable,
  .duplex_status_pin);

// >>> rtl/ecc_control.sv
// Operation
// - Reset clears codec power/gain word; it holds until the host writes it again.
// - Codec shutdown bit one powers the whole codec down.
// - Speaker-driver shutdown bit powers down only the speaker driver.
// - Mic gain-bypass bit routes the microphone around the 26 dB preamp.
// - Transmit volume field attenuates transmit samples 3 dB per unit.
// - Network-canceller disable gives the acoustic canceller the full 64 ms.
// - Decay grading defaults to 0.38 dB/ms; a two-bit field changes it.
// - Cancellers adapt from live speech only; no training signal ever.
// - Half-duplex suppression is on after reset until cancellers are trained.
// - In half duplex only one direction passes until its talker stops.
// - Leave half duplex once measured ERLE exceeds a fixed threshold.
// - Duplex status pin always shows half or full duplex.
// - Full duplex adds supplementary transmit suppression by gain control.
// - Once trained, stay in full duplex when noise later rises.
// - Receive gain control on unless disable bit set or volume is 10.
// - Mute/gain pin sampled after reset; high disables 26 dB mic gain.
// - From 1 ms, pin change mutes transmit and sets receive fully on.
// - Returning the pin to its reset level unmutes the microphone.
`timescale 1ns/10ps
module ecc_control
  import ecc_pkg::*;
#(
  parameter int STRAP_DELAY_CYCLES = STRAP_DELAY_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic link_wr_valid,
  output logic link_wr_ready,
  input wire ecc_word_wr_t link_wr,
  input wire logic [1:0] link_rd_sel,
  output logic [11:0] link_rd_data,
  input wire logic sample_valid,
  input wire logic signed [15:0] tx_sample_in,
  output logic signed [15:0] serial_out_pin,
  input wire logic far_active,
  input wire logic near_active,
  input wire logic [7:0] erle_level,
  input wire logic mute_gain_pin,
  input wire logic [2:0] control_code_pins,
  output ecc_codec_ctl_t codec_ctl,
  output ecc_cancel_ctl_t cancel_ctl,
  output logic [3:0] tx_volume_field,
  output logic [5:0] rx_volume,
  output logic rx_agc_enable,
  output logic rx_pass,
  output logic rx_full_on,
  output logic tx_suppress_enable,
  output logic duplex_status_pin
);

  function automatic logic signed [15:0] atten_3db(
    input logic signed [15:0] x,
    input logic [3:0] steps
  );
    logic signed [15:0] h;
    h = x >>> steps[3:1];
    if (steps[0]) begin
      // Multiply by about 0.703, close enough to one 3 dB step.
      h = (h >>> 1) + (h >>> 3) + (h >>> 4) + (h >>> 6);
    end
    return h;
  endfunction

  // Link side: words are captured here and handed over by a toggle.
  logic req_tgl_reg;
  logic ack_tgl_link;
  logic ack_tgl_reg;
  ecc_word_wr_t hold_reg;
  logic [11:0] shadow_reg [0:2];
  logic [11:0] rd_data_reg;
  logic [11:0] wr_masked;

  always_comb begin
    if (link_wr.sel == WORD_CODEC_POWER_GAIN) begin
      wr_masked = link_wr.data & CODEC_POWER_GAIN_MASK;
    end else if (link_wr.sel == WORD_TEST_CONTROL) begin
      wr_masked = link_wr.data & TEST_CONTROL_MASK;
    end else begin
      wr_masked = link_wr.data;
    end
  end

  // A new word is refused while the previous one is still crossing.
  assign link_wr_ready = (req_tgl_reg == ack_tgl_link);

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      req_tgl_reg <= 1'b0;
      hold_reg <= '0;
    end else if (link_wr_valid && link_wr_ready && link_wr.sel <= 2'h2) begin
      req_tgl_reg <= ~req_tgl_reg;
      hold_reg <= '{sel: link_wr.sel, data: wr_masked};
    end
  end

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      shadow_reg[WORD_CANCELLER_CONFIG] <= CANCELLER_CONFIG_RESET;
      shadow_reg[WORD_TEST_CONTROL] <= TEST_CONTROL_RESET;
      shadow_reg[WORD_CODEC_POWER_GAIN] <= CODEC_POWER_GAIN_RESET;
    end else if (link_wr_valid && link_wr_ready && link_wr.sel <= 2'h2) begin
      shadow_reg[link_wr.sel] <= wr_masked;
    end
  end

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      rd_data_reg <= 12'h000;
    end else if (link_rd_sel <= 2'h2) begin
      rd_data_reg <= shadow_reg[link_rd_sel];
    end else begin
      rd_data_reg <= 12'h000;
    end
  end

  assign link_rd_data = rd_data_reg;

  ecc_sync3 #(.WIDTH(1)) u_ack_sync (
    .clk(link_clk),
    .rst(rst),
    .async_in(ack_tgl_reg),
    .sync_out(ack_tgl_link)
  );

  // Core side.
  logic req_tgl_core;
  logic [11:0] word_reg [0:2];

  ecc_sync3 #(.WIDTH(1)) u_req_sync (
    .clk(clk),
    .rst(rst),
    .async_in(req_tgl_reg),
    .sync_out(req_tgl_core)
  );

  // Hold data is stable for the whole handshake, so it may be read here.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_tgl_reg <= 1'b0;
    end else if (req_tgl_core != ack_tgl_reg) begin
      ack_tgl_reg <= req_tgl_core;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      word_reg[WORD_CANCELLER_CONFIG] <= CANCELLER_CONFIG_RESET;
      word_reg[WORD_TEST_CONTROL] <= TEST_CONTROL_RESET;
      word_reg[WORD_CODEC_POWER_GAIN] <= CODEC_POWER_GAIN_RESET;
    end else if (req_tgl_core != ack_tgl_reg) begin
      word_reg[hold_reg.sel] <= hold_reg.data;
    end
  end

  logic [11:0] codec_word;
  logic [11:0] cfg_word;
  logic [11:0] test_word;
  assign codec_word = word_reg[WORD_CODEC_POWER_GAIN];
  assign cfg_word = word_reg[WORD_CANCELLER_CONFIG];
  assign test_word = word_reg[WORD_TEST_CONTROL];

  // Mute/gain pin: strap after reset, then mute on any departure from it.
  logic mute_pin_sync;
  logic [31:0] reset_cnt_reg;
  logic strap_reg;
  logic mute_reg;

  ecc_sync3 #(.WIDTH(1)) u_mute_sync (
    .clk(clk),
    .rst(rst),
    .async_in(mute_gain_pin),
    .sync_out(mute_pin_sync)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reset_cnt_reg <= 32'h0000_0000;
    end else if (reset_cnt_reg < 32'(STRAP_DELAY_CYCLES)) begin
      reset_cnt_reg <= reset_cnt_reg + 32'h0000_0001;
    end
  end

  // The strap is caught once the synchroniser has filled, not at reset.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_reg <= 1'b0;
    end else if (reset_cnt_reg == 32'(STRAP_SAMPLE_CYC)) begin
      strap_reg <= mute_pin_sync;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mute_reg <= 1'b0;
    end else if (reset_cnt_reg >= 32'(STRAP_DELAY_CYCLES)) begin
      mute_reg <= (mute_pin_sync != strap_reg);
    end else begin
      mute_reg <= 1'b0;
    end
  end

  // Control code pins: a code must stand three samples before it acts.
  logic [2:0] code_sync;
  logic [2:0] code_last_reg;
  logic [1:0] code_cnt_reg;
  logic code_done_reg;
  logic code_take;
  logic hd_code_off_reg;
  logic code_clear;
  logic [5:0] volume_reg;

  ecc_sync3 #(.WIDTH(3)) u_code_sync (
    .clk(clk),
    .rst(rst),
    .async_in(control_code_pins),
    .sync_out(code_sync)
  );

  assign code_take = sample_valid && (code_sync == code_last_reg) &&
                     (code_cnt_reg == CODE_HOLD_SAMPLES - 2'h1) &&
                     !code_done_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      code_last_reg <= CODE_HD_ENABLE;
      code_cnt_reg <= 2'h0;
      code_done_reg <= 1'b1;
    end else if (code_sync != code_last_reg) begin
      code_last_reg <= code_sync;
      code_cnt_reg <= 2'h0;
      code_done_reg <= 1'b0;
    end else if (code_take) begin
      code_done_reg <= 1'b1;
    end else if (sample_valid && !code_done_reg) begin
      code_cnt_reg <= code_cnt_reg + 2'h1;
    end
  end

  // Clear lasts only while the clear code is held after being taken.
  assign code_clear = code_done_reg && (code_last_reg == CODE_COEF_CLEAR);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hd_code_off_reg <= 1'b0;
    end else if (code_take && (code_last_reg == CODE_HD_DISABLE_A ||
                               code_last_reg == CODE_HD_DISABLE_B)) begin
      hd_code_off_reg <= 1'b1;
    end else if (code_take && code_last_reg == CODE_HD_ENABLE) begin
      hd_code_off_reg <= 1'b0;
    end
  end

  // Volume steps run 0 loudest to 41 quietest; out-of-range steps are held.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      volume_reg <= VOLUME_RESET;
    end else if (code_take && code_last_reg == CODE_VOLUME_UP &&
                 volume_reg != 6'h00) begin
      volume_reg <= volume_reg - 6'h01;
    end else if (code_take && code_last_reg == CODE_VOLUME_DOWN &&
                 volume_reg != VOLUME_MAX) begin
      volume_reg <= volume_reg + 6'h01;
    end
  end

  // Duplex state.
  ecc_duplex_t duplex_reg;
  ecc_duplex_t duplex_next;
  logic coef_clear;
  logic hd_disabled;

  assign coef_clear = test_word[AEC_COEF_CLEAR_BIT] | code_clear;
  assign hd_disabled = test_word[HALF_DUPLEX_DISABLE_BIT] | hd_code_off_reg;

  always_comb begin
    duplex_next = duplex_reg;
    case (duplex_reg)
      DUPLEX_HALF: begin
        if (hd_disabled) begin
          duplex_next = DUPLEX_FULL;
        end else if (!coef_clear && erle_level > ERLE_THRESHOLD) begin
          duplex_next = DUPLEX_FULL;
        end
      end
      DUPLEX_FULL: begin
        // A later fall in ERLE from noise does not drop back to half.
        if (coef_clear && !hd_disabled) begin
          duplex_next = DUPLEX_HALF;
        end
      end
      default: begin
        duplex_next = DUPLEX_HALF;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      duplex_reg <= DUPLEX_HALF;
    end else begin
      duplex_reg <= duplex_next;
    end
  end

  assign duplex_status_pin = (duplex_reg == DUPLEX_FULL);

  // Talker direction used only in half duplex.
  ecc_dir_t dir_reg;
  ecc_dir_t dir_next;

  always_comb begin
    dir_next = dir_reg;
    case (dir_reg)
      DIR_IDLE: begin
        if (far_active) begin
          dir_next = DIR_RX;
        end else if (near_active) begin
          dir_next = DIR_TX;
        end
      end
      DIR_RX: begin
        if (!far_active) begin
          dir_next = DIR_IDLE;
        end
      end
      DIR_TX: begin
        if (!near_active) begin
          dir_next = DIR_IDLE;
        end
      end
      default: begin
        dir_next = DIR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dir_reg <= DIR_IDLE;
    end else if (duplex_reg == DUPLEX_FULL) begin
      dir_reg <= DIR_IDLE;
    end else begin
      dir_reg <= dir_next;
    end
  end

  logic tx_pass;
  assign tx_pass = (duplex_reg == DUPLEX_FULL) || (dir_reg == DIR_TX);
  assign rx_pass = (duplex_reg == DUPLEX_FULL) || (dir_reg == DIR_RX) ||
                   mute_reg;

  // Transmit samples: muted, blocked or attenuated.
  logic signed [15:0] tx_out_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_out_reg <= 16'sh0000;
    end else if (sample_valid) begin
      if (mute_reg || !tx_pass) begin
        tx_out_reg <= 16'sh0000;
      end else begin
        tx_out_reg <= atten_3db(tx_sample_in,
                                codec_word[TX_VOLUME_LSB +: 4]);
      end
    end
  end

  assign serial_out_pin = tx_out_reg;

  // Codec and canceller controls.
  assign codec_ctl.codec_power_down = codec_word[CODEC_SHUTDOWN_BIT];
  assign codec_ctl.speaker_power_down =
    codec_word[SPEAKER_SHUTDOWN_BIT];
  assign codec_ctl.mic_gain_bypass =
    codec_word[MIC_BYPASS_BIT] | strap_reg;
  assign tx_volume_field = codec_word[TX_VOLUME_LSB +: 4];

  assign cancel_ctl.net_canceller_enable =
    !cfg_word[NET_CANCEL_DISABLE_BIT];
  assign cancel_ctl.aec_full_span = cfg_word[NET_CANCEL_DISABLE_BIT];
  assign cancel_ctl.decay_rate = cfg_word[DECAY_FIELD_LSB +: 2];
  assign cancel_ctl.aec_coef_clear = coef_clear;
  assign cancel_ctl.nec_coef_clear = test_word[NEC_COEF_CLEAR_BIT];
  // Adaptation is paced only by live samples; nothing synthesises a probe.
  assign cancel_ctl.adapt_strobe = sample_valid &&
                                   (far_active || near_active);

  assign tx_suppress_enable = (duplex_reg == DUPLEX_FULL) &&
                              !test_word[SUPPRESSION_DISABLE_BIT];
  assign rx_volume = volume_reg;
  assign rx_agc_enable = !test_word[GAIN_CTL_DISABLE_BIT] &&
                         (volume_reg != VOLUME_AGC_OFF);
  assign rx_full_on = mute_reg;

endmodule // ecc_control

// >>> rtl/ecc_pkg.sv
package ecc_pkg;

  localparam int CLK_HZ = 100_000_000;
  localparam int STRAP_DELAY_MS = 1;
  localparam int STRAP_DELAY_CYC = CLK_HZ / 1000 * STRAP_DELAY_MS;
  localparam int STRAP_SAMPLE_CYC = 4;
  localparam logic [1:0] CODE_HOLD_SAMPLES = 2'h3;

  localparam logic [1:0] WORD_CANCELLER_CONFIG = 2'h0;
  localparam logic [1:0] WORD_TEST_CONTROL = 2'h1;
  localparam logic [1:0] WORD_CODEC_POWER_GAIN = 2'h2;

  localparam logic [11:0] CANCELLER_CONFIG_RESET = 12'h00a;
  localparam logic [11:0] TEST_CONTROL_RESET = 12'h000;
  localparam logic [11:0] CODEC_POWER_GAIN_RESET = 12'h000;
  localparam logic [11:0] CODEC_POWER_GAIN_MASK = 12'he0f;
  localparam logic [11:0] TEST_CONTROL_MASK = 12'hccf;

  localparam int CODEC_SHUTDOWN_BIT = 11;
  localparam int SPEAKER_SHUTDOWN_BIT = 10;
  localparam int MIC_BYPASS_BIT = 9;
  localparam int TX_VOLUME_LSB = 0;
  localparam int NET_CANCEL_DISABLE_BIT = 8;
  localparam int DECAY_FIELD_LSB = 2;
  localparam int GAIN_CTL_DISABLE_BIT = 10;
  localparam int HALF_DUPLEX_DISABLE_BIT = 2;
  localparam int SUPPRESSION_DISABLE_BIT = 1;
  localparam int NEC_COEF_CLEAR_BIT = 3;
  localparam int AEC_COEF_CLEAR_BIT = 0;

  localparam logic [7:0] ERLE_THRESHOLD = 8'h30;
  localparam logic [5:0] VOLUME_RESET = 6'h04;
  localparam logic [5:0] VOLUME_MAX = 6'h29;
  localparam logic [5:0] VOLUME_AGC_OFF = 6'h0a;

  localparam logic [2:0] CODE_HD_ENABLE = 3'h0;
  localparam logic [2:0] CODE_COEF_CLEAR = 3'h1;
  localparam logic [2:0] CODE_HD_DISABLE_A = 3'h3;
  localparam logic [2:0] CODE_HD_DISABLE_B = 3'h7;
  localparam logic [2:0] CODE_VOLUME_UP = 3'h6;
  localparam logic [2:0] CODE_VOLUME_DOWN = 3'h5;

  typedef enum logic [0:0] {
    DUPLEX_HALF = 1'b0,
    DUPLEX_FULL = 1'b1
  } ecc_duplex_t;

  typedef enum logic [1:0] {
    DIR_IDLE = 2'b00,
    DIR_RX = 2'b01,
    DIR_TX = 2'b10
  } ecc_dir_t;

  typedef struct packed {
    logic [1:0] sel;
    logic [11:0] data;
  } ecc_word_wr_t;

  typedef struct packed {
    logic codec_power_down;
    logic speaker_power_down;
    logic mic_gain_bypass;
  } ecc_codec_ctl_t;

  typedef struct packed {
    logic net_canceller_enable;
    logic aec_full_span;
    logic [1:0] decay_rate;
    logic aec_coef_clear;
    logic nec_coef_clear;
    logic adapt_strobe;
  } ecc_cancel_ctl_t;

endpackage

// >>> rtl/ecc_sync3.sv
`timescale 1ns/10ps
module ecc_sync3
  import ecc_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  logic [WIDTH-1:0] out_reg;

  // Only the second stage reads the first, so metastability stays contained.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_reg <= '0;
    end else if (stage2_reg == stage3_reg) begin
      out_reg <= stage3_reg;
    end
  end

  assign sync_out = out_reg;

endmodule // ecc_sync3
